// >>> dar_host.sv
// Purpose: Host side readout of a dual simultaneous-sampling converter
// Assumes: serial clock made here by a divider of core_clk; device
//          status and data pins are asynchronous and synchronised
// Notes:   One frame serves both data lanes; single-lane mode reads
//          the second result after the first on lane A
//
// How it works
// - Device conversion status acts as interrupt; reading starts only after it falls
// - Host makes its own transmit frame and drives it to device select
// - Frame is held low for the whole word transfer
// - One frame output serves both receive lanes in the same frame
// - On conversion done, a dummy word is sent; that raises the frame
// - Receive framing is taken from the transmit frame
// - Each data bit is captured on the falling serial clock edge
// - Dual-lane receive word is 14 bits, or 16 bits ending in two bits of the other result; single-lane reads RES_BITS+14
// - Primary and secondary lanes capture both outputs on one clock
// - Burst mode runs the serial clock continuously; select gates data
// - In burst mode the host makes both clock and frame itself
// - Convert-start falling edge begins conversion; status high while converting
// - Select low for 14 more clocks gives the other result on one line

module dar_host #(
  parameter int RES_BITS = 14,
  parameter int SCLK_HALF = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start_req,
  input wire logic word_length_setting,
  input wire logic dual_lane,
  input wire logic burst_mode,
  input wire logic conv_busy,
  input wire logic result_out_a,
  input wire logic result_out_b,
  output logic convert_start_n,
  output logic host_tx_frame_sync_n,
  output logic host_rx_frame_sync_n,
  output logic host_rx_serial_clock,
  output logic host_tx_data,
  output logic [dar_pkg::RES_W-1:0] result_a,
  output logic [dar_pkg::RES_W-1:0] result_b,
  output logic result_valid,
  output logic ctrl_busy
);
  import dar_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // Two sync stages must settle inside one half period of the serial clock
  if (RES_BITS != 12 && RES_BITS != 14) begin : g_bad_res
    $error("RES_BITS must be 12 or 14");
  end
  // The first fall comes SCLK_HALF-1 cycles after the frame drops, so 3 would sample a stale MSB
  if (SCLK_HALF < 4 || SCLK_HALF > 255) begin : g_bad_half
    $error("SCLK_HALF must lie in 4..255");
  end

  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(SCLK_HALF - 1);
  localparam logic [BIT_W-1:0] SINGLE_BITS = BIT_W'(RES_BITS + SECOND_WORD_BITS);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] sync1_reg;
  logic [2:0] sync1_next;
  logic [2:0] sync2_reg;
  logic [2:0] sync2_next;
  logic busy_s;
  logic dat_a_s;
  logic dat_b_s;

  always_comb begin
    sync1_next = {conv_busy, result_out_b, result_out_a};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  assign dat_a_s = sync2_reg[0];
  assign dat_b_s = sync2_reg[1];
  assign busy_s = sync2_reg[2];

  // ************************************************************
  // Serial clock divider
  // ************************************************************
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic phase_reg;
  logic phase_next;
  logic sclk_fall;
  logic sclk_rise;

  always_comb begin
    div_next = (div_reg == HALF_LAST) ? '0 : div_reg + DIV_W'(1);
    phase_next = (div_reg == HALF_LAST) ? ~phase_reg : phase_reg;
  end

  assign sclk_fall = (div_reg == HALF_LAST) && phase_reg;
  assign sclk_rise = (div_reg == HALF_LAST) && !phase_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      div_reg <= '0;
      phase_reg <= 1'b1;
    end else begin
      div_reg <= div_next;
      phase_reg <= phase_next;
    end
  end

  // ************************************************************
  // Conversion and read sequencer
  // ************************************************************
  dar_state_e state_reg;
  dar_state_e state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [BIT_W-1:0] bit_reg;
  logic [BIT_W-1:0] bit_next;
  logic [BIT_W-1:0] total_reg;
  logic [BIT_W-1:0] total_next;
  logic dual_reg;
  logic dual_next;
  logic burst_reg;
  logic burst_next;
  logic [SHIFT_W-1:0] sh_a_reg;
  logic [SHIFT_W-1:0] sh_a_next;
  logic [RES_W-1:0] sh_b_reg;
  logic [RES_W-1:0] sh_b_next;
  logic [RES_W-1:0] tx_reg;
  logic [RES_W-1:0] tx_next;
  logic cnv_n_reg;
  logic cnv_n_next;
  logic fs_n_reg;
  logic fs_n_next;
  logic rfs_n_reg;
  logic rfs_n_next;
  logic sclk_reg;
  logic sclk_next;
  logic txd_reg;
  logic txd_next;
  logic [RES_W-1:0] res_a_reg;
  logic [RES_W-1:0] res_a_next;
  logic [RES_W-1:0] res_b_reg;
  logic [RES_W-1:0] res_b_next;
  logic valid_reg;
  logic valid_next;
  logic busy_reg;
  logic busy_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    total_next = total_reg;
    dual_next = dual_reg;
    burst_next = burst_mode;
    sh_a_next = sh_a_reg;
    sh_b_next = sh_b_reg;
    tx_next = tx_reg;
    cnv_n_next = cnv_n_reg;
    fs_n_next = fs_n_reg;
    res_a_next = res_a_reg;
    res_b_next = res_b_reg;
    valid_next = 1'b0;
    case (state_reg)
      DAR_IDLE: begin
        if (start_req) begin
          // Falling convert-start begins both conversions
          cnv_n_next = 1'b0;
          cnt_next = CNT_W'(CNV_LOW_CYC - 1);
          dual_next = dual_lane;
          if (!dual_lane) begin
            total_next = SINGLE_BITS;
          end else if (word_length_setting) begin
            total_next = BIT_W'(WORD_LONG);
          end else begin
            total_next = BIT_W'(WORD_SHORT);
          end
          state_next = DAR_CNV_LOW;
        end
      end
      DAR_CNV_LOW: begin
        if (cnt_reg == '0) begin
          cnv_n_next = 1'b1;
          state_next = DAR_WAIT_HI;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      DAR_WAIT_HI: begin
        if (busy_s) begin
          state_next = DAR_WAIT_LO;
        end
      end
      DAR_WAIT_LO: begin
        // Status falling is the interrupt; frame drops at a high clock phase
        // so the first falling clock edge never coincides with select
        if (!busy_s && phase_reg && div_reg == '0) begin
          fs_n_next = 1'b0;
          tx_next = DUMMY_WORD;
          bit_next = '0;
          sh_a_next = SHIFT_RST;
          sh_b_next = RESULT_RST;
          state_next = DAR_SHIFT;
        end
      end
      DAR_SHIFT: begin
        if (sclk_fall && bit_reg != total_reg) begin
          // Both lanes sample on the same falling edge
          sh_a_next = {sh_a_reg[SHIFT_W-2:0], dat_a_s};
          sh_b_next = {sh_b_reg[RES_W-2:0], dat_b_s};
          tx_next = {tx_reg[RES_W-2:0], 1'b0};
          bit_next = bit_reg + BIT_W'(1);
        end else if (sclk_rise && bit_reg == total_reg) begin
          fs_n_next = 1'b1;
          cnt_next = CNT_W'(QUIET_CYC - 1);
          valid_next = 1'b1;
          if (dual_reg) begin
            // 14-bit word is right-justified with upper bits zero; a 16-bit word ends in two bits of the other result
            res_a_next = sh_a_reg[RES_W-1:0];
            res_b_next = sh_b_reg;
          end else begin
            res_a_next = RES_W'(sh_a_reg[SECOND_WORD_BITS +: RES_BITS]);
            res_b_next = RES_W'(sh_a_reg[RES_BITS-1:0]);
          end
          state_next = DAR_QUIET;
        end
      end
      DAR_QUIET: begin
        if (cnt_reg == '0) begin
          state_next = DAR_IDLE;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      default: begin
        state_next = DAR_IDLE;
        cnv_n_next = 1'b1;
        fs_n_next = 1'b1;
      end
    endcase
    // Receive frame is a copy of the transmit frame
    rfs_n_next = fs_n_next;
    // Clock idles high outside a frame unless burst mode keeps it running
    sclk_next = (burst_reg || state_next == DAR_SHIFT) ? phase_next : 1'b1;
    txd_next = (state_next == DAR_SHIFT) ? tx_next[RES_W-1] : 1'b0;
    busy_next = (state_next != DAR_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg <= DAR_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      total_reg <= BIT_W'(WORD_SHORT);
      dual_reg <= 1'b1;
      burst_reg <= 1'b0;
      sh_a_reg <= SHIFT_RST;
      sh_b_reg <= RESULT_RST;
      tx_reg <= DUMMY_WORD;
      cnv_n_reg <= 1'b1;
      fs_n_reg <= 1'b1;
      rfs_n_reg <= 1'b1;
      sclk_reg <= 1'b1;
      txd_reg <= 1'b0;
      res_a_reg <= RESULT_RST;
      res_b_reg <= RESULT_RST;
      valid_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      total_reg <= total_next;
      dual_reg <= dual_next;
      burst_reg <= burst_next;
      sh_a_reg <= sh_a_next;
      sh_b_reg <= sh_b_next;
      tx_reg <= tx_next;
      cnv_n_reg <= cnv_n_next;
      fs_n_reg <= fs_n_next;
      rfs_n_reg <= rfs_n_next;
      sclk_reg <= sclk_next;
      txd_reg <= txd_next;
      res_a_reg <= res_a_next;
      res_b_reg <= res_b_next;
      valid_reg <= valid_next;
      busy_reg <= busy_next;
    end
  end

  assign convert_start_n = cnv_n_reg;
  assign host_tx_frame_sync_n = fs_n_reg;
  assign host_rx_frame_sync_n = rfs_n_reg;
  assign host_rx_serial_clock = sclk_reg;
  assign host_tx_data = txd_reg;
  assign result_a = res_a_reg;
  assign result_b = res_b_reg;
  assign result_valid = valid_reg;
  assign ctrl_busy = busy_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_frame_drop;
    $fell(fs_n_reg);
  endsequence

  sequence s_last_bit;
    (state_reg == DAR_SHIFT) && (bit_reg == total_reg) && sclk_rise;
  endsequence

  a_read_after_done: assert property (s_frame_drop |-> !sync2_reg[2] && $past(state_reg) == DAR_WAIT_LO)
    else $error("Frame fell before conversion status was low");

  a_frame_held_low: assert property ((state_reg == DAR_SHIFT && $past(state_reg) == DAR_SHIFT)
                                     |-> !fs_n_reg)
    else $error("Frame rose during a word transfer");

  a_rx_tracks_tx: assert property (rfs_n_reg == fs_n_reg)
    else $error("Receive frame differs from transmit frame");

  a_dummy_on_frame: assert property (s_frame_drop |-> !txd_reg && tx_reg == DUMMY_WORD)
    else $error("Dummy word not loaded when frame fell");

  a_cnv_pulse_width: assert property ($fell(cnv_n_reg) |-> !cnv_n_reg ##1 !cnv_n_reg ##1 cnv_n_reg)
    else $error("Convert-start low pulse has wrong length");

  a_sample_on_fall: assert property ((bit_reg != $past(bit_reg) && bit_reg != '0) |-> $fell(sclk_reg))
    else $error("Bit taken away from a falling serial clock");

  a_word_count: assert property ($rose(fs_n_reg) |-> $past(bit_reg) == total_reg
                                 && (total_reg == BIT_W'(WORD_SHORT) || total_reg == BIT_W'(WORD_LONG)
                                 || total_reg == SINGLE_BITS))
    else $error("Frame ended after a wrong bit count");

  a_frame_ends: assert property (s_last_bit |=> fs_n_reg && valid_reg ##1 !valid_reg)
    else $error("Frame not raised after the last bit");

  a_burst_clock: assert property ((burst_reg && state_reg == DAR_IDLE && $past(burst_reg))
                                  |-> ##[1:300] $changed(sclk_reg))
    else $error("Serial clock idle in burst mode");

  a_lanes_together: assert property ((state_reg == DAR_SHIFT && sclk_fall && bit_reg != total_reg)
                                     |=> sh_a_reg[0] == $past(dat_a_s) && sh_b_reg[0] == $past(dat_b_s))
    else $error("Lanes not captured on the same edge");

endmodule

// >>> dar_pkg.sv
// Purpose: Shared constants for the dual converter serial readout host
// Assumes: core_clk at 50 MHz; device result width 12 or 14 bits
// Notes:   Times are kept in ns and turned into cycle counts here

// ************************************************************
// Package
// ************************************************************
package dar_pkg;

  localparam int CLK_PERIOD_NS = 20;

  // Convert-start low pulse, a least time
  localparam int T_CNV_LOW_NS = 40;
  localparam int CNV_LOW_CYC = (T_CNV_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Quiet time after a read before the next convert-start, a least time
  localparam int T_QUIET_NS = 100;
  localparam int QUIET_CYC = (T_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Word lengths of the receiver
  localparam int WORD_SHORT = 14;
  localparam int WORD_LONG = 16;
  // Extra clocks for the other channel on one lane
  localparam int SECOND_WORD_BITS = 14;

  // Field widths
  localparam int CNT_W = 16;
  localparam int BIT_W = 6;
  localparam int SHIFT_W = 32;
  localparam int RES_W = 16;
  localparam int DIV_W = 8;

  // Dummy control word sent to raise the frame
  localparam logic [RES_W-1:0] DUMMY_WORD = 16'h0000;

  // Values after reset
  localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [SHIFT_W-1:0] SHIFT_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    DAR_IDLE,
    DAR_CNV_LOW,
    DAR_WAIT_HI,
    DAR_WAIT_LO,
    DAR_SHIFT,
    DAR_QUIET
  } dar_state_e;

endpackage

// >>> dar_dev_model.sv
// Purpose: Behavioural dual converter facing the readout host
// Assumes: RES_BITS is 12 or 14; codes are set before convert-start falls
// Notes:   Released data lines show the inverse of their last value

module dar_dev_model #(
  parameter int RES_BITS = 14,
  parameter int CONV_NS = 600
) (
  input wire logic convert_start_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [13:0] code_a,
  input wire logic [13:0] code_b,
  output logic conv_busy,
  output logic result_out_a,
  output logic result_out_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [27:0] stream_a;
  logic [27:0] stream_b;
  int idx;

  // ************************************************************
  // Result streams
  // ************************************************************
  // The narrower part puts two zeros ahead of the other result
  function automatic logic [27:0] pack_words(input logic [13:0] first, input logic [13:0] second);
    pack_words = {14'h0000, first} << (28 - RES_BITS);
    pack_words = pack_words | ({14'h0000, second} << (14 - RES_BITS));
  endfunction

  initial begin
    conv_busy = 1'b0;
    result_out_a = 1'b0;
    result_out_b = 1'b1;
    stream_a = '0;
    stream_b = '0;
    idx = 0;
  end

  // ************************************************************
  // Conversion
  // ************************************************************
  // Status is the only completion hint the host gets
  always @(negedge convert_start_n) begin
    stream_a <= pack_words(code_a, code_b);
    stream_b <= pack_words(code_b, code_a);
    conv_busy <= #15 1'b1;
    conv_busy <= #(CONV_NS) 1'b0;
  end

  // ************************************************************
  // Serial output
  // ************************************************************
  always @(negedge cs_n) begin
    idx = 0;
    result_out_a <= stream_a[27];
    result_out_b <= stream_b[27];
  end

  // Later bits move on falling clock only while selected
  always @(negedge sclk) begin
    if (cs_n === 1'b0) begin
      idx = idx + 1;
      result_out_a <= #5 (idx < 28) ? stream_a[27 - idx] : 1'b0;
      result_out_b <= #5 (idx < 28) ? stream_b[27 - idx] : 1'b0;
    end
  end

  // No pull on the lines: a stale value must not pass for data
  always @(posedge cs_n) begin
    result_out_a <= ~result_out_a;
    result_out_b <= ~result_out_b;
  end
endmodule

// >>> dar_host_bench.sv
// Purpose: Self-checking bench of the dual converter readout host
// Assumes: 14-bit device model; serial clock made by the host
// Notes:   Edge counters run all the time, level monitors only out of reset; all are checked per read

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end

module dar_host_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import dar_pkg::*;
  logic core_clk, resetn, start_req, word_length_setting, dual_lane, burst_mode;
  logic conv_busy, result_out_a, result_out_b, convert_start_n, host_tx_frame_sync_n;
  logic host_rx_frame_sync_n, host_rx_serial_clock, host_tx_data, result_valid, ctrl_busy;
  logic [RES_W-1:0] result_a;
  logic [RES_W-1:0] result_b;
  logic [13:0] code_a;
  logic [13:0] code_b;
  int fails, checked, falls, idle_falls, convs, rx_miss, early_frame, tx_ones;

  dar_host #(.RES_BITS(14), .SCLK_HALF(4)) dut_u (.core_clk(core_clk), .resetn(resetn),
    .start_req(start_req), .word_length_setting(word_length_setting), .dual_lane(dual_lane),
    .burst_mode(burst_mode), .conv_busy(conv_busy), .result_out_a(result_out_a),
    .result_out_b(result_out_b), .convert_start_n(convert_start_n),
    .host_tx_frame_sync_n(host_tx_frame_sync_n), .host_rx_frame_sync_n(host_rx_frame_sync_n),
    .host_rx_serial_clock(host_rx_serial_clock), .host_tx_data(host_tx_data),
    .result_a(result_a), .result_b(result_b), .result_valid(result_valid), .ctrl_busy(ctrl_busy));

  dar_dev_model #(.RES_BITS(14), .CONV_NS(600)) dev_u (.convert_start_n(convert_start_n),
    .cs_n(host_tx_frame_sync_n), .sclk(host_rx_serial_clock), .code_a(code_a), .code_b(code_b),
    .conv_busy(conv_busy), .result_out_a(result_out_a), .result_out_b(result_out_b));

  // ************************************************************
  // Clock, monitors, watchdog
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(negedge host_rx_serial_clock) begin
    if (host_tx_frame_sync_n === 1'b0) falls++;
    else idle_falls++;
  end

  always @(negedge convert_start_n) convs++;

  always @(posedge core_clk) begin
    if (resetn === 1'b1) begin
      if (host_rx_frame_sync_n !== host_tx_frame_sync_n) rx_miss++;
      if (host_tx_frame_sync_n === 1'b0 && conv_busy === 1'b1) early_frame++;
      if (host_tx_data !== 1'b0) tx_ones++;
    end
  end

  // Five reads take about 1000 cycles; allow twenty times that
  initial begin
    #400000;
    fails++;
    close_out();
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic close_out();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // start_req is held into ctrl_busy so the extra cycles must be ignored
  task automatic run_read(input logic dl, input logic wl, input logic bm, input logic [13:0] a,
                          input logic [13:0] b, input int n, input logic [15:0] ea, input logic [15:0] eb);
    int k;
    code_a = a;
    code_b = b;
    falls = 0;
    idle_falls = 0;
    convs = 0;
    @(posedge core_clk);
    dual_lane <= dl;
    word_length_setting <= wl;
    burst_mode <= bm;
    start_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    start_req <= 1'b0;
    k = 0;
    while (result_valid !== 1'b1 && k < 2000) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    `CHK(k < 2000, 1'b1);
    `CHK(result_a, ea);
    `CHK(result_b, eb);
    `CHK(falls, n);
    @(posedge core_clk);
    #1;
    `CHK(result_valid, 1'b0);
    k = 1;
    while (ctrl_busy === 1'b1 && k < 50) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    `CHK(k, QUIET_CYC);
    `CHK(convs, 1);
    `CHK(idle_falls > 0, bm);
    `CHK(rx_miss, 0);
    `CHK(early_frame, 0);
    `CHK(tx_ones, 0);
  endtask

  task automatic t_reset();
    `CHK(convert_start_n, 1'b1);
    `CHK(host_tx_frame_sync_n, 1'b1);
    `CHK(host_rx_serial_clock, 1'b1);
    `CHK(result_valid, 1'b0);
    `CHK(ctrl_busy, 1'b0);
    `CHK(result_a, RESULT_RST);
    $display("test reset done");
  endtask

  task automatic t_dual14();
    run_read(1'b1, 1'b0, 1'b0, 14'h2A5C, 14'h1F03, WORD_SHORT, 16'h2A5C, 16'h1F03);
    $display("test dual14 done");
  endtask

  // Two clocks past a 14-bit result bring in the other result's top bits
  task automatic t_dual16();
    run_read(1'b1, 1'b1, 1'b0, 14'h3FFF, 14'h0001, WORD_LONG, 16'hFFFC, 16'h0007);
    $display("test dual16 done");
  endtask

  task automatic t_single();
    run_read(1'b0, 1'b0, 1'b0, 14'h0001, 14'h3FFE, 14 + SECOND_WORD_BITS, 16'h0001, 16'h3FFE);
    $display("test single done");
  endtask

  task automatic t_burst();
    run_read(1'b1, 1'b0, 1'b1, 14'h1555, 14'h2AAA, WORD_SHORT, 16'h1555, 16'h2AAA);
    $display("test burst done");
  endtask

  // A reset in mid-frame must release the device select and park the link
  task automatic t_midreset();
    int k;
    @(posedge core_clk);
    dual_lane <= 1'b1;
    word_length_setting <= 1'b0;
    start_req <= 1'b1;
    @(posedge core_clk);
    start_req <= 1'b0;
    k = 0;
    while (host_tx_frame_sync_n !== 1'b0 && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    `CHK(k < 2000, 1'b1);
    repeat (20) @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(host_tx_frame_sync_n, 1'b1);
    `CHK(host_rx_frame_sync_n, 1'b1);
    `CHK(host_rx_serial_clock, 1'b1);
    `CHK(ctrl_busy, 1'b0);
    @(posedge core_clk);
    resetn <= 1'b1;
    $display("test midreset done");
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    fails = 0;
    checked = 0;
    rx_miss = 0;
    early_frame = 0;
    tx_ones = 0;
    resetn = 1'b0;
    start_req = 1'b0;
    word_length_setting = 1'b0;
    dual_lane = 1'b1;
    burst_mode = 1'b0;
    code_a = 14'h0000;
    code_b = 14'h0000;
    repeat (10) @(posedge core_clk);
    #1;
    t_reset();
    @(posedge core_clk);
    resetn <= 1'b1;
    t_dual14();
    t_midreset();
    t_dual14();
    t_dual16();
    t_single();
    t_burst();
    close_out();
  end
endmodule
